// ---- src/sensor_map.svh ----
`ifndef SENSOR_MAP_SVH
`define SENSOR_MAP_SVH

// Byte addresses seen through the serial pointer.
`define OFS_PART_IDENTIFIER       8'h00
`define OFS_SI_REV        8'h01
`define OFS_SEQ_REV       8'h02
`define OFS_IRQ_PIN_CFG   8'h03
`define OFS_IRQ_ENABLE    8'h04
`define OFS_HW_UNLOCK     8'h07
`define OFS_WAKE_LO       8'h08
`define OFS_WAKE_HI       8'h09
`define OFS_EMIT_ONE_TWO  8'h0F
`define OFS_EMIT_THREE    8'h10
`define OFS_UV_COEF0      8'h13
`define OFS_UV_COEF1      8'h14
`define OFS_UV_COEF2      8'h15
`define OFS_UV_COEF3      8'h16
`define OFS_PARAMETER_WRITE_MAILBOX      8'h17
`define OFS_HOST_CMD      8'h18
`define OFS_CMD_REPLY     8'h20
`define OFS_IRQ_FLAGS     8'h21
`define OFS_VIS_LO        8'h22
`define OFS_VIS_HI        8'h23
`define OFS_IR_LO         8'h24
`define OFS_IR_HI         8'h25
`define OFS_PROX1_LO      8'h26
`define OFS_PROX1_HI      8'h27
`define OFS_PROX2_LO      8'h28
`define OFS_PROX2_HI      8'h29
`define OFS_PROX3_LO      8'h2A
`define OFS_PROX3_HI      8'h2B
`define OFS_AUX_LO        8'h2C
`define OFS_AUX_HI        8'h2D
`define OFS_PARAMETER_READ_MAILBOX      8'h2E
`define OFS_CHIP_STATE    8'h30
`define OFS_ANA_KEY0      8'h3B
`define OFS_ANA_KEY1      8'h3C
`define OFS_ANA_KEY2      8'h3D
`define OFS_ANA_KEY3      8'h3E

// Field positions.
`define PIN_DRIVE_BIT     0
`define AMBIENT_BIT       0
`define PROX_ONE_BIT      2
`define PROX_TWO_BIT      3
`define PROX_THREE_BIT    4
`define CMD_DONE_BIT      5
`define LIST_VIS_BIT      4
`define LIST_UV_BIT       7

// Writable bit masks and reset values.
`define PIN_CFG_WMASK     8'h01
`define ENABLE_WMASK      8'h1D
`define FLAGS_MASK        8'h3D
`define EMIT_THREE_WMASK  8'h0F
`define REG_RESET         8'h00

`endif

// ---- src/sensor_pkg.sv ----
package sensor_pkg;

	typedef logic [7:0] byte_t;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_ADDR     = 3'b001,
		ST_ACK_ADDR = 3'b010,
		ST_WRITE    = 3'b011,
		ST_ACK_WR   = 3'b100,
		ST_READ     = 3'b101,
		ST_ACK_RD   = 3'b110
	} serial_state_t;

endpackage : sensor_pkg

// ---- src/serial_target.sv ----
`timescale 1ns/100ps
`default_nettype none

module serial_target import sensor_pkg::*; #(
	parameter logic [6:0] TARGET_ADDR = 7'h2A
) (
	input  wire logic  clock,
	input  wire logic  rstn,
	input  wire logic  scl_in,
	input  wire logic  sda_in,
	input  wire byte_t rdata,
	output var  logic  sda_oe_n,
	output var  byte_t reg_ptr,
	output var  logic  wr_stb,
	output var  byte_t wr_addr,
	output var  byte_t wr_data
);

	logic          scl_meta_r;
	logic          scl_sync_r;
	logic          scl_prev_r;
	logic          sda_meta_r;
	logic          sda_sync_r;
	logic          sda_prev_r;
	serial_state_t state_r;
	logic [3:0]    bit_cnt_r;
	byte_t         shift_r;
	logic          read_r;
	logic          ptr_phase_r;
	logic          acked_r;
	logic          scl_rise;
	logic          scl_fall;
	logic          bus_start;
	logic          bus_stop;

	// Both pins pass three flops; edges are taken from the second and third stage only.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			scl_meta_r <= 1'b1;
			scl_sync_r <= 1'b1;
			scl_prev_r <= 1'b1;
			sda_meta_r <= 1'b1;
			sda_sync_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end else begin
			scl_meta_r <= scl_in;
			scl_sync_r <= scl_meta_r;
			scl_prev_r <= scl_sync_r;
			sda_meta_r <= sda_in;
			sda_sync_r <= sda_meta_r;
			sda_prev_r <= sda_sync_r;
		end
	end

	assign scl_rise  = scl_sync_r & ~scl_prev_r;
	assign scl_fall  = ~scl_sync_r & scl_prev_r;
	assign bus_start = scl_sync_r & scl_prev_r & sda_prev_r & ~sda_sync_r;
	assign bus_stop  = scl_sync_r & scl_prev_r & ~sda_prev_r & sda_sync_r;

	// The first data byte of a write sets the pointer; later bytes store and step it.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_r     <= ST_IDLE;
			bit_cnt_r   <= 4'h0;
			shift_r     <= 8'h00;
			read_r      <= 1'b0;
			ptr_phase_r <= 1'b0;
			acked_r     <= 1'b0;
			sda_oe_n    <= 1'b1;
			reg_ptr     <= 8'h00;
			wr_stb      <= 1'b0;
			wr_addr     <= 8'h00;
			wr_data     <= 8'h00;
		end else begin
			wr_stb <= 1'b0;
			if (bus_start) begin
				state_r   <= ST_ADDR;
				bit_cnt_r <= 4'h0;
				sda_oe_n  <= 1'b1;
			end else if (bus_stop) begin
				state_r  <= ST_IDLE;
				sda_oe_n <= 1'b1;
			end else if (scl_rise) begin
				case (state_r)
					ST_ADDR, ST_WRITE: begin
						shift_r   <= {shift_r[6:0], sda_sync_r};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
					ST_ACK_RD: begin
						acked_r <= ~sda_sync_r;
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (state_r)
					ST_ADDR: begin
						if (bit_cnt_r == 4'h8) begin
							if (shift_r[7:1] == TARGET_ADDR) begin
								sda_oe_n <= 1'b0;
								read_r   <= shift_r[0];
								state_r  <= ST_ACK_ADDR;
							end else begin
								state_r <= ST_IDLE;
							end
						end
					end
					ST_WRITE: begin
						if (bit_cnt_r == 4'h8) begin
							sda_oe_n <= 1'b0;
							state_r  <= ST_ACK_WR;
							if (ptr_phase_r) begin
								reg_ptr     <= shift_r;
								ptr_phase_r <= 1'b0;
							end else begin
								wr_stb  <= 1'b1;
								wr_addr <= reg_ptr;
								wr_data <= shift_r;
								reg_ptr <= reg_ptr + 8'h01;
							end
						end
					end
					ST_ACK_ADDR, ST_ACK_RD: begin
						if (state_r == ST_ACK_RD && !acked_r) begin
							state_r  <= ST_IDLE;
							sda_oe_n <= 1'b1;
						end else if (state_r == ST_ACK_RD || read_r) begin
							shift_r   <= rdata;
							sda_oe_n  <= rdata[7];
							bit_cnt_r <= 4'h1;
							state_r   <= ST_READ;
						end else begin
							sda_oe_n    <= 1'b1;
							bit_cnt_r   <= 4'h0;
							ptr_phase_r <= 1'b1;
							state_r     <= ST_WRITE;
						end
					end
					ST_ACK_WR: begin
						sda_oe_n  <= 1'b1;
						bit_cnt_r <= 4'h0;
						state_r   <= ST_WRITE;
					end
					ST_READ: begin
						if (bit_cnt_r == 4'h8) begin
							sda_oe_n <= 1'b1;
							reg_ptr  <= reg_ptr + 8'h01;
							state_r  <= ST_ACK_RD;
						end else begin
							sda_oe_n  <= shift_r[3'd7 - bit_cnt_r[2:0]];
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
					end
					default: begin
						state_r <= ST_IDLE;
					end
				endcase
			end
		end
	end

endmodule : serial_target

`default_nettype wire

// ---- src/sensor_register_map_irq_out.sv ----
// How it works
// - Pin drive bit clear: interrupt pin never driven.
// - Drive bit set: pin low while flag&enable.
// - Enable bit 4 gates third proximity flag.
// - Enable bit 3 gates second proximity flag.
// - Enable bit 2 gates first proximity flag.
// - Enable bit 0 gates listed visible/UV results.
// - Flag register at 0x21 holds five flags.
// - Writing one clears only that flag bit.
// - Proximity flag set after every enabled sample.
`timescale 1ns/100ps
`default_nettype none
`include "sensor_map.svh"

module sensor_register_map_irq_out import sensor_pkg::*; #(
	parameter logic [6:0] TARGET_ADDR = 7'h2A,
	parameter byte_t      PART_CODE   = 8'hA5, // Arbitrary value.
	parameter byte_t      SI_REV_CODE = 8'h5A, // Arbitrary value.
	parameter byte_t      SEQ_CODE    = 8'h3C  // Arbitrary value.
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output var  logic        sda_out,
	output var  logic        sda_oe_n,
	output var  logic        irq_out,
	output var  logic        irq_oe_n,
	input  wire logic        cmd_done_evt,
	input  wire logic [2:0]  prox_evt,
	input  wire logic        ambient_evt,
	input  wire byte_t       channel_select_list,
	input  wire logic        state_active,
	input  wire logic        state_suspend,
	input  wire logic        state_sleep,
	input  wire logic        reply_wr,
	input  wire byte_t       reply_data,
	input  wire logic [15:0] vis_result,
	input  wire logic [15:0] ir_result,
	input  wire logic [15:0] prox_one_result,
	input  wire logic [15:0] prox_two_result,
	input  wire logic [15:0] prox_three_result,
	input  wire logic [15:0] aux_result,
	input  wire byte_t       parameter_read_mailbox_data,
	output var  byte_t       hw_unlock,
	output var  logic [15:0] wake_interval,
	output var  byte_t       emitter_current_one_two,
	output var  byte_t       emitter_current_three,
	output var  logic [31:0] uv_coefficients,
	output var  byte_t       parameter_write_mailbox_data,
	output var  byte_t       host_cmd,
	output var  logic        host_cmd_stb,
	output var  logic [31:0] analog_unlock
);

	byte_t       reg_ptr;
	byte_t       rdata;
	logic        wr_stb;
	byte_t       wr_addr;
	byte_t       wr_data;
	logic        target_sda_oe_n;
	byte_t       pin_cfg_r;
	byte_t       irq_enable_r;
	byte_t       irq_flags_r;
	byte_t       irq_flags_nxt;
	byte_t       flag_set;
	byte_t       flag_clr;
	byte_t       cmd_reply_r;
	logic        ambient_listed;
	logic        irq_match;
	logic [1:0]  key_idx;

	serial_target #(
		.TARGET_ADDR (TARGET_ADDR)
	) u_serial (
		.clock    (clock),
		.rstn     (rstn),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.rdata    (rdata),
		.sda_oe_n (target_sda_oe_n),
		.reg_ptr  (reg_ptr),
		.wr_stb   (wr_stb),
		.wr_addr  (wr_addr),
		.wr_data  (wr_data)
	);

	assign sda_oe_n = target_sda_oe_n;
	assign key_idx  = wr_addr[1:0] - 2'b11;

	// Open-drain pins only ever pull low, so their data flop never leaves zero.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			sda_out <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			irq_out <= 1'b0;
		end
	end

	// Host-writable configuration and mailboxes.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			pin_cfg_r               <= `REG_RESET;
			irq_enable_r            <= `REG_RESET;
			hw_unlock               <= `REG_RESET;
			wake_interval           <= 16'h0000;
			emitter_current_one_two <= `REG_RESET;
			emitter_current_three   <= `REG_RESET;
			uv_coefficients         <= 32'h0000_0000;
			parameter_write_mailbox_data           <= `REG_RESET;
			host_cmd                <= `REG_RESET;
			host_cmd_stb            <= 1'b0;
			analog_unlock           <= 32'h0000_0000;
		end else begin
			host_cmd_stb <= 1'b0;
			if (wr_stb) begin
				case (wr_addr)
					`OFS_IRQ_PIN_CFG:  pin_cfg_r <= wr_data & `PIN_CFG_WMASK;
					`OFS_IRQ_ENABLE:   irq_enable_r <= wr_data & `ENABLE_WMASK;
					`OFS_HW_UNLOCK:    hw_unlock <= wr_data;
					`OFS_WAKE_LO:      wake_interval[7:0] <= wr_data;
					`OFS_WAKE_HI:      wake_interval[15:8] <= wr_data;
					`OFS_EMIT_ONE_TWO: emitter_current_one_two <= wr_data;
					`OFS_EMIT_THREE:   emitter_current_three <= wr_data & `EMIT_THREE_WMASK;
					`OFS_UV_COEF0:     uv_coefficients[7:0] <= wr_data;
					`OFS_UV_COEF1:     uv_coefficients[15:8] <= wr_data;
					`OFS_UV_COEF2:     uv_coefficients[23:16] <= wr_data;
					`OFS_UV_COEF3:     uv_coefficients[31:24] <= wr_data;
					`OFS_PARAMETER_WRITE_MAILBOX:     parameter_write_mailbox_data <= wr_data;
					`OFS_HOST_CMD: begin
						host_cmd     <= wr_data;
						host_cmd_stb <= 1'b1;
					end
					`OFS_ANA_KEY0, `OFS_ANA_KEY1, `OFS_ANA_KEY2, `OFS_ANA_KEY3: begin
						analog_unlock[8*key_idx +: 8] <= wr_data;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// The sequencer's reply overrides a host write landing in the same cycle.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			cmd_reply_r <= `REG_RESET;
		end else if (reply_wr) begin
			cmd_reply_r <= reply_data;
		end else if (wr_stb && wr_addr == `OFS_CMD_REPLY) begin
			cmd_reply_r <= wr_data;
		end
	end

	assign ambient_listed = channel_select_list[`LIST_VIS_BIT] | channel_select_list[`LIST_UV_BIT];

	// A proximity or ambient channel whose enable is clear never raises its flag; the command-done flag is set without any enable.
	always_comb begin
		flag_set                  = 8'h00;
		flag_set[`CMD_DONE_BIT]   = cmd_done_evt;
		flag_set[`PROX_THREE_BIT] = prox_evt[2] & irq_enable_r[`PROX_THREE_BIT];
		flag_set[`PROX_TWO_BIT]   = prox_evt[1] & irq_enable_r[`PROX_TWO_BIT];
		flag_set[`PROX_ONE_BIT]   = prox_evt[0] & irq_enable_r[`PROX_ONE_BIT];
		flag_set[`AMBIENT_BIT]    = ambient_evt & ambient_listed & irq_enable_r[`AMBIENT_BIT];
		flag_clr = 8'h00;
		if (wr_stb && wr_addr == `OFS_IRQ_FLAGS) begin
			flag_clr = wr_data & `FLAGS_MASK;
		end
		// A set arriving with its own clear is kept so no sample is lost.
		irq_flags_nxt = ((irq_flags_r & ~flag_clr) | flag_set) & `FLAGS_MASK;
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			irq_flags_r <= `REG_RESET;
		end else begin
			irq_flags_r <= irq_flags_nxt;
		end
	end

	assign irq_match = |(irq_flags_r & irq_enable_r);

	// Pulled low only while drive is on and a flag meets its enable; otherwise released.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			irq_oe_n <= 1'b1;
		end else begin
			irq_oe_n <= ~(pin_cfg_r[`PIN_DRIVE_BIT] & irq_match);
		end
	end

	// Unmapped and reserved addresses read as zero.
	always_comb begin
		case (reg_ptr)
			`OFS_PART_IDENTIFIER:      rdata = PART_CODE;
			`OFS_SI_REV:       rdata = SI_REV_CODE;
			`OFS_SEQ_REV:      rdata = SEQ_CODE;
			`OFS_IRQ_PIN_CFG:  rdata = pin_cfg_r;
			`OFS_IRQ_ENABLE:   rdata = irq_enable_r;
			`OFS_HW_UNLOCK:    rdata = hw_unlock;
			`OFS_WAKE_LO:      rdata = wake_interval[7:0];
			`OFS_WAKE_HI:      rdata = wake_interval[15:8];
			`OFS_EMIT_ONE_TWO: rdata = emitter_current_one_two;
			`OFS_EMIT_THREE:   rdata = emitter_current_three;
			`OFS_UV_COEF0:     rdata = uv_coefficients[7:0];
			`OFS_UV_COEF1:     rdata = uv_coefficients[15:8];
			`OFS_UV_COEF2:     rdata = uv_coefficients[23:16];
			`OFS_UV_COEF3:     rdata = uv_coefficients[31:24];
			`OFS_PARAMETER_WRITE_MAILBOX:     rdata = parameter_write_mailbox_data;
			`OFS_HOST_CMD:     rdata = host_cmd;
			`OFS_CMD_REPLY:    rdata = cmd_reply_r;
			`OFS_IRQ_FLAGS:    rdata = irq_flags_r;
			`OFS_VIS_LO:       rdata = vis_result[7:0];
			`OFS_VIS_HI:       rdata = vis_result[15:8];
			`OFS_IR_LO:        rdata = ir_result[7:0];
			`OFS_IR_HI:        rdata = ir_result[15:8];
			`OFS_PROX1_LO:     rdata = prox_one_result[7:0];
			`OFS_PROX1_HI:     rdata = prox_one_result[15:8];
			`OFS_PROX2_LO:     rdata = prox_two_result[7:0];
			`OFS_PROX2_HI:     rdata = prox_two_result[15:8];
			`OFS_PROX3_LO:     rdata = prox_three_result[7:0];
			`OFS_PROX3_HI:     rdata = prox_three_result[15:8];
			`OFS_AUX_LO:       rdata = aux_result[7:0];
			`OFS_AUX_HI:       rdata = aux_result[15:8];
			`OFS_PARAMETER_READ_MAILBOX:     rdata = parameter_read_mailbox_data;
			`OFS_CHIP_STATE:   rdata = {5'b00000, state_active, state_suspend, state_sleep};
			`OFS_ANA_KEY0:     rdata = analog_unlock[7:0];
			`OFS_ANA_KEY1:     rdata = analog_unlock[15:8];
			`OFS_ANA_KEY2:     rdata = analog_unlock[23:16];
			`OFS_ANA_KEY3:     rdata = analog_unlock[31:24];
			default:           rdata = 8'h00;
		endcase
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	AST_PIN_NEVER_DRIVEN: assert property (
		!pin_cfg_r[`PIN_DRIVE_BIT] |=> irq_oe_n
	) else $error("Interrupt pin driven while drive is disabled.");

	AST_PIN_LOW_ON_MATCH: assert property (
		pin_cfg_r[`PIN_DRIVE_BIT] && irq_match |=> !irq_oe_n
	) else $error("Interrupt pin not pulled low on a flag match.");

	AST_PROX_THREE_PIN: assert property (
		irq_enable_r[`PROX_THREE_BIT] && prox_evt[2] && pin_cfg_r[`PIN_DRIVE_BIT]
		&& !(wr_stb && (wr_addr == `OFS_IRQ_ENABLE || wr_addr == `OFS_IRQ_PIN_CFG))
		|=> irq_flags_r[`PROX_THREE_BIT] ##1 !irq_oe_n
	) else $error("Third proximity event did not assert the pin in two cycles.");

	AST_PROX_THREE_GATED: assert property (
		!irq_enable_r[`PROX_THREE_BIT] |=> !$rose(irq_flags_r[`PROX_THREE_BIT])
	) else $error("Third proximity flag rose while its enable was clear.");

	AST_PROX_TWO_GATED: assert property (
		!irq_enable_r[`PROX_TWO_BIT] && !irq_flags_r[`PROX_TWO_BIT]
		|=> !irq_flags_r[`PROX_TWO_BIT]
	) else $error("Second proximity flag set while its enable was clear.");

	AST_PROX_ONE_SET: assert property (
		irq_enable_r[`PROX_ONE_BIT] && prox_evt[0] |=> irq_flags_r[`PROX_ONE_BIT]
	) else $error("First proximity sample did not set its flag.");

	AST_AMBIENT_GATED: assert property (
		ambient_evt && !irq_flags_r[`AMBIENT_BIT]
		|=> irq_flags_r[`AMBIENT_BIT] == ($past(irq_enable_r[`AMBIENT_BIT]) && $past(ambient_listed))
	) else $error("Ambient flag does not follow enable and channel list.");

	AST_CMD_DONE_SET: assert property (
		cmd_done_evt |=> irq_flags_r[`CMD_DONE_BIT]
	) else $error("Command-done event did not set its flag.");

	AST_W1C_ONLY_THAT_BIT: assert property (
		wr_stb && wr_addr == `OFS_IRQ_FLAGS && !cmd_done_evt && prox_evt == 3'b000 && !ambient_evt
		|=> irq_flags_r == ($past(irq_flags_r) & ~$past(wr_data))
	) else $error("Writing ones did not clear exactly those flags.");

	AST_PROX_TWO_SAMPLE: assert property (
		irq_enable_r[`PROX_TWO_BIT] && prox_evt[1] |=> irq_flags_r[`PROX_TWO_BIT]
	) else $error("Second proximity sample did not set its flag.");

	AST_PIN_RELEASED: assert property (
		!irq_match [*2] |-> irq_oe_n
	) else $error("Interrupt pin held low with no pending match.");

endmodule : sensor_register_map_irq_out

`default_nettype wire

// ---- bench/i2c_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module i2c_host_model import sensor_pkg::*; #(
	parameter logic [6:0] TARGET_ADDR = 7'h2A,
	parameter int         HALF        = 5
) (
	input  wire logic clock,
	input  wire logic sda,
	output var  logic scl,
	output var  logic sda_oe_n
);
	int nacks = 0;

	initial begin
		scl = 1'h1;
		sda_oe_n = 1'h1;
	end

	task automatic tick();
		repeat (HALF) @(negedge clock);
	endtask : tick

	// Data moves a full phase after scl falls, so the target never takes it for a start or a stop.
	task automatic bit_io(input logic b, output logic r);
		sda_oe_n = b;
		tick();
		scl = 1'h1;
		tick();
		r = sda;
		scl = 1'h0;
		tick();
	endtask : bit_io

	task automatic bus_start();
		sda_oe_n = 1'h1;
		tick();
		scl = 1'h1;
		tick();
		sda_oe_n = 1'h0;
		tick();
		scl = 1'h0;
		tick();
	endtask : bus_start

	task automatic bus_stop();
		sda_oe_n = 1'h0;
		tick();
		scl = 1'h1;
		tick();
		sda_oe_n = 1'h1;
		tick();
	endtask : bus_stop

	task automatic send(input byte_t d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'h1, r);
		if (r !== 1'h0) nacks++;
	endtask : send

	// Single-byte reads only, so every received byte is answered with a not-acknowledge.
	task automatic recv(output byte_t d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'h1, r);
			d[i] = r;
		end
		bit_io(1'h1, r);
	endtask : recv

	task automatic reg_write(input byte_t a, input byte_t d);
		bus_start();
		send({TARGET_ADDR, 1'h0});
		send(a);
		send(d);
		bus_stop();
	endtask : reg_write

	task automatic reg_read(input byte_t a, output byte_t d);
		bus_start();
		send({TARGET_ADDR, 1'h0});
		send(a);
		bus_start();
		send({TARGET_ADDR, 1'h1});
		recv(d);
		bus_stop();
	endtask : reg_read

	task automatic clear_pending(output byte_t seen);
		reg_read(8'h21, seen);
		reg_write(8'h21, seen);
	endtask : clear_pending
endmodule : i2c_host_model

`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb import sensor_pkg::*; ;
	localparam logic [6:0] ADDR  = 7'h2A;
	localparam byte_t      PART  = 8'hA5; // Arbitrary value.
	localparam byte_t      SIREV = 8'h5A; // Arbitrary value.
	localparam byte_t      SEQ   = 8'h3C; // Arbitrary value.

	logic        clock = 1'h0;
	logic        rstn = 1'h0;
	logic        scl, host_oe_n, sda, sda_out, sda_oe_n, irq_out, irq_oe_n, irq_pin, host_cmd_stb;
	logic        cmd_done_evt = 1'h0, ambient_evt = 1'h0, reply_wr = 1'h0;
	logic [2:0]  prox_evt = 3'h0;
	logic [2:0]  chip_st = 3'h6;
	byte_t       channel_select_list = 8'h00, reply_data = 8'h00, parameter_read_mailbox = 8'h9E;
	byte_t       hw_unlock, emit12, emit3, parameter_write_mailbox_data, host_cmd, got, cfg, en, ev, flags, pin;
	logic [15:0] wake_interval;
	logic [31:0] uv_coefficients, analog_unlock;
	logic [95:0] live = 96'hA1B2_C3D4_E5F6_0718_293A_4B5C;
	int          fails = 0, compares = 0, stb_count = 0;

	// Address, byte written, byte expected back; read-only places must ignore the write.
	logic [23:0] reg_rows [23] = '{
		24'h03FF01, 24'h04FF1D, 24'h071717, 24'h083434, 24'h091212, 24'h0FA5A5, 24'h10FF0F, 24'h130101,
		24'h140202, 24'h150303, 24'h160404, 24'h173333, 24'h18C6C6, 24'h20C3C3, {16'h0000, PART},
		{16'h0100, SIREV}, {16'h0200, SEQ}, 24'h2EFF9E, 24'h30FF06, 24'h3B1111, 24'h3C2222, 24'h3D3333,
		24'h3E4444};
	// Pin config, enables, channel list, event mask {cmd, ambient, prox3..1}, flags read, pin level.
	logic [47:0] irq_rows [12] = '{
		48'h01_04_00_01_04_00, 48'h01_00_00_01_00_01, 48'h01_08_00_02_08_00, 48'h01_00_00_02_00_01,
		48'h01_10_00_04_10_00, 48'h01_00_00_04_00_01, 48'h01_01_10_08_01_00, 48'h01_01_80_08_01_00,
		48'h01_01_00_08_00_01, 48'h01_00_90_08_00_01, 48'h00_1D_00_01_04_01, 48'h01_1D_00_10_20_01};

	assign sda = (sda_oe_n === 1'h0) ? sda_out : host_oe_n;
	assign irq_pin = (irq_oe_n === 1'h0) ? irq_out : 1'h1;

	always #10 clock = ~clock;

	always @(posedge clock) if (host_cmd_stb === 1'h1) stb_count++;

	sensor_register_map_irq_out #(
		.TARGET_ADDR(ADDR), .PART_CODE(PART), .SI_REV_CODE(SIREV), .SEQ_CODE(SEQ)
	) sensor_register_map_irq_out_i (
		.clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.irq_out(irq_out), .irq_oe_n(irq_oe_n), .cmd_done_evt(cmd_done_evt), .prox_evt(prox_evt),
		.ambient_evt(ambient_evt), .channel_select_list(channel_select_list), .state_active(chip_st[2]),
		.state_suspend(chip_st[1]), .state_sleep(chip_st[0]), .reply_wr(reply_wr), .reply_data(reply_data),
		.vis_result(live[15:0]), .ir_result(live[31:16]), .prox_one_result(live[47:32]),
		.prox_two_result(live[63:48]), .prox_three_result(live[79:64]), .aux_result(live[95:80]),
		.parameter_read_mailbox_data(parameter_read_mailbox), .hw_unlock(hw_unlock), .wake_interval(wake_interval),
		.emitter_current_one_two(emit12), .emitter_current_three(emit3), .uv_coefficients(uv_coefficients),
		.parameter_write_mailbox_data(parameter_write_mailbox_data), .host_cmd(host_cmd), .host_cmd_stb(host_cmd_stb),
		.analog_unlock(analog_unlock)
	);

	i2c_host_model #(.TARGET_ADDR(ADDR)) host_i (
		.clock(clock), .sda(sda), .scl(scl), .sda_oe_n(host_oe_n)
	);

	task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v, input string what);
		compares++;
		if (got_v !== exp_v) begin
			fails++;
			$display("unexpected at %0t ns: %s is %h, expected %h", $time, what, got_v, exp_v);
		end
	endtask : check

	task automatic pulse(input logic [4:0] m);
		{cmd_done_evt, ambient_evt, prox_evt} = m;
		@(negedge clock);
		{cmd_done_evt, ambient_evt, prox_evt} = 5'h00;
		repeat (2) @(negedge clock);
	endtask : pulse

	task automatic end_of_test();
		if (fails == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test

	// The full sequence needs about 60k cycles; this leaves margin without letting a hang run on.
	initial begin
		#1_900_000;
		fails++;
		end_of_test();
	end

	initial begin
		repeat (10) @(negedge clock);
		check({irq_oe_n, sda_oe_n, host_cmd_stb, wake_interval}, 19'h60000, "outputs in reset");
		repeat (10) @(negedge clock);
		rstn = 1'h1;
		repeat (5) @(negedge clock);
		foreach (reg_rows[i]) begin
			host_i.reg_write(reg_rows[i][23:16], reg_rows[i][15:8]);
			host_i.reg_read(reg_rows[i][23:16], got);
			check(got, reg_rows[i][7:0], "register readback");
		end
		for (int k = 0; k < 12; k++) begin
			host_i.reg_read(8'h22 + 8'(k), got);
			check(got, live[8*k +: 8], "result byte");
		end
		host_i.reg_write(8'h0A, 8'h55);
		check({hw_unlock, wake_interval, emit12}, 32'h171234A5, "control outputs");
		check({emit3, parameter_write_mailbox_data, host_cmd, 8'(stb_count)}, 32'h0F33C601, "mailbox outputs");
		check(uv_coefficients, 32'h04030201, "uv coefficients");
		check(analog_unlock, 32'h44332211, "analog unlock");
		foreach (irq_rows[i]) begin
			{cfg, en, channel_select_list, ev, flags, pin} = irq_rows[i];
			host_i.reg_write(8'h03, cfg);
			host_i.reg_write(8'h04, en);
			pulse(ev[4:0]);
			check(irq_pin, 32'(pin), "pin after event");
			host_i.clear_pending(got);
			check(got, flags, "flags read");
			check(irq_pin, 1'h1, "pin after clear");
			channel_select_list = 8'h00;
		end
		host_i.reg_write(8'h04, 8'h0C);
		pulse(5'h03);
		host_i.reg_write(8'h21, 8'h04);
		check(irq_pin, 1'h0, "pin with one flag left");
		host_i.reg_read(8'h21, got);
		check(got, 8'h08, "flags after one clear");
		host_i.reg_write(8'h21, 8'h08);
		check(irq_pin, 1'h1, "pin after last clear");
		host_i.reg_write(8'h04, 8'h1D);
		host_i.reg_write(8'h03, 8'h00);
		pulse(5'h04);
		check(irq_pin, 1'h1, "pin with drive off");
		host_i.reg_write(8'h03, 8'h01);
		check(irq_pin, 1'h0, "pin with drive on");
		host_i.reg_write(8'h03, 8'h00);
		check(irq_pin, 1'h1, "pin after drive off");
		reply_data = 8'h5C;
		reply_wr = 1'h1;
		@(negedge clock);
		reply_wr = 1'h0;
		host_i.reg_read(8'h20, got);
		check(got, 8'h5C, "reply register");
		host_i.reg_write(8'h03, 8'h01);
		rstn = 1'h0;
		repeat (2) @(negedge clock);
		check({irq_pin, wake_interval, host_cmd}, 25'h1000000, "outputs after second reset");
		rstn = 1'h1;
		repeat (5) @(negedge clock);
		host_i.reg_read(8'h03, got);
		check(got, 8'h00, "pin config after reset");
		check(32'(host_i.nacks), 32'h0, "acknowledges");
		end_of_test();
	end
endmodule : tb

`default_nettype wire
